/* rtl/tif_consts.svh */
// Register offsets, field positions and reset values of the timer block.
// Assumes byte addresses on a 32-bit APB, one register per aligned word.
`ifndef TIF_CONSTS_SVH
`define TIF_CONSTS_SVH
`define TIF_OFS_RES_HI   8'h00
`define TIF_OFS_RES_LO   8'h04
`define TIF_OFS_WAKE     8'h08
`define TIF_OFS_FLAGS    8'h0c
`define TIF_OFS_TCTRL    8'h10
`define TIF_OFS_C1CTRL   8'h14
`define TIF_OFS_C23CTRL  8'h18
`define TIF_OFS_WMASK    8'h1c
`define TIF_OFS_FMASK    8'h20
`define TIF_OFS_AUXCTRL  8'h24
`define TIF_OFS_TMR      8'h28
`define TIF_OFS_CNT1     8'h2c
`define TIF_OFS_CNT2     8'h30
`define TIF_OFS_CNT3     8'h34
`define TIF_RST_BYTE     8'h00
`define TIF_RST_WORD     16'h0000
`define TIF_WAKE_WMASK   8'h0e
`define TIF_C1_WMASK     8'h1f
`define TIF_C23_WMASK    8'hf7
`define TIF_BIT_EXTEDGE  7
`define TIF_BIT_GIE      6
`define TIF_BIT_TSRC     5
`define TIF_BIT_TEDGE    4
`define TIF_BIT_MAIN_PRESCALER_ENABLE     3
`define TIF_BIT_CONVERSION_DONE_FLAG     5
`define TIF_BIT_COMPARATOR_CHANGE_FLAG    4
`define TIF_BIT_CONVERSION_WAKE_ENABLE     3
`define TIF_BIT_COMPARATOR_WAKE_ENABLE    2
`define TIF_BIT_PORT_CHANGE_WAKE_ENABLE     1
`define TIF_BIT_CMPOUT   5
`define TIF_BIT_WIDE     7
`define TIF_BIT_CONVRUN  0
`define TIF_BIT_FOURCLK  1
`define TIF_FULL_PMASK   8'hff
`define TIF_MAX8         16'h00ff
`define TIF_MAX16        16'hffff
`endif

/* rtl/tif_pkg.sv */
// Types shared by the timer and interrupt flag block.
// Assumes the constants header is included where offsets are needed.
package tif_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tif_apb_req_t;
  typedef struct packed {
    logic       cmpOut;
    logic [7:0] port5;
    logic       extInt;
    logic       cnt3Pin;
    logic       cnt2Pin;
    logic       cnt1Pin;
    logic       tccPin;
  } tif_pins_t;
  typedef struct packed {
    logic        adcDone;
    logic [11:0] adcResult;
    logic        lowPulseUf;
    logic        highPulseUf;
    logic        irqDisable;
    logic        irqOn;
    logic        irqReturn;
    logic        irqTaken;
  } tif_hw_t;
endpackage : tif_pkg

/* rtl/tif_top.sv */
// Main timer, three auxiliary counters, interrupt and wake flags, APB slave.
// Assumes clk_sys is the instruction cycle clock; hw events are synchronous.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "tif_consts.svh"

// Function
// (RULE1) Conversion end loads result, clears running, flags
// (RULE2) Wake/status read is ANDed with mask
// (RULE3) Software only clears bits five and four
// (RULE4) Conversion done flag sticky until cleared
// (RULE5) Comparator change flag sticky until cleared
// (RULE6) Bits three..one enable wake sources
// (RULE7) Flag bit one means request pending
// (RULE8) Flag register read ANDed with mask
// (RULE9) Software writes only clear flag bits
// (RULE10) Pulse timer underflows set bits seven, six
// (RULE11) Counter three overflow sets bit five
// (RULE12) Counters two, one set bits four, three
// (RULE13) External edge and port change flags
// (RULE14) Main timer overflow sets bit zero
// (RULE15) Control bit seven selects external edge
// (RULE16) Bit six shows global interrupt enable
// (RULE17) Bit five selects main timer clock
// (RULE18) Bit four selects counted pin edge
// (RULE19) Prescaler enable and ratio code
// (RULE20) Overflow period scales with instruction mode
// (RULE21) Counter one enable, bit five read-only
// (RULE22) Counter one clock source and edge
// (RULE23) Counter two eight or sixteen bits
// (RULE24) Counter two enable, source, edge
// (RULE25) Counters increment, wrap, flag on wrap
// (RULE26) Mask bits five, four gate interrupts
module tif_top (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // APB slave
  input  wire tif_pkg::tif_apb_req_t apbReq,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Pins and hardware events
  input  wire tif_pkg::tif_pins_t   pins,
  input  wire tif_pkg::tif_hw_t     hwEvt,
  // Status towards the core
  output logic                      irqReq,
  output logic                      wakeReq,
  output logic                      globalIrqEnable,
  output logic                      conversionRunning
);
  import tif_pkg::*;

  // Pin synchronisers and edge history
  logic [13:0] pinMeta_r;
  logic [13:0] pinSync_r;
  logic [13:0] pinPrev_r;
  logic [13:0] pinRaw;
  logic [13:0] pinRise;
  logic [13:0] pinFall;
  logic [13:0] pinChg;

  // Register storage
  logic [7:0]  tctrl_r;
  logic [7:0]  c1ctrl_r;
  logic [7:0]  c23ctrl_r;
  logic [7:0]  wakeMask_r;
  logic [7:0]  flagMask_r;
  logic [7:0]  wake_r;
  logic [7:0]  wake_nxt;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [7:0]  flagSet;
  logic [7:0]  resHi_r;
  logic [7:0]  resLo_r;
  logic        convRun_r;
  logic        fourClk_r;
  logic        phase_r;
  logic        gie_r;

  // Main timer
  logic [7:0]  tmr_r;
  logic [7:0]  presc_r;
  logic [7:0]  pMask;
  logic        cycleTick;
  logic        tmrSrcEvt;
  logic        tmrEvt;
  logic        tmrOvf;
  logic        tccPinEvt;

  // Auxiliary counters
  logic [15:0] auxCnt_r [3];
  logic [2:0]  auxEn;
  logic [2:0]  auxSrc;
  logic [2:0]  auxEdge;
  logic [2:0]  auxOvf;

  // Bus decode
  logic        setupPh;
  logic        wrEn;
  logic        mapped;
  logic [31:0] rdMux;
  logic        wrWake;
  logic        wrFlags;
  logic        wrAux;
  logic [7:0]  wdByte;
  logic        extEdge;
  logic        cmpChg;
  logic        portChg;

  assign pinRaw  = pins;
  assign pinRise = pinSync_r & ~pinPrev_r;
  assign pinFall = ~pinSync_r & pinPrev_r;
  assign pinChg  = pinSync_r ^ pinPrev_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinMeta_r <= 14'h0000;
      pinSync_r <= 14'h0000;
      pinPrev_r <= 14'h0000;
    end
    else
    begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  // APB decode and read mux
  assign setupPh = apbReq.psel & ~apbReq.penable;
  assign wrEn    = apbReq.psel & apbReq.penable & pready & apbReq.pwrite;
  assign wdByte  = apbReq.pwdata[7:0];
  assign wrWake  = wrEn & (apbReq.paddr == `TIF_OFS_WAKE);
  assign wrFlags = wrEn & (apbReq.paddr == `TIF_OFS_FLAGS);
  assign wrAux   = wrEn & (apbReq.paddr == `TIF_OFS_AUXCTRL);

  always_comb
  begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    case (apbReq.paddr)
      `TIF_OFS_RES_HI:  rdMux[7:0] = resHi_r;
      `TIF_OFS_RES_LO:  rdMux[7:0] = resLo_r;
      // (RULE2) masked status read
      `TIF_OFS_WAKE:    rdMux[7:0] = wake_r & wakeMask_r;
      // (RULE8) masked flag read
      `TIF_OFS_FLAGS:   rdMux[7:0] = flags_r & flagMask_r;
      // (RULE16) enable shown read-only
      `TIF_OFS_TCTRL:   rdMux[7:0] = {tctrl_r[7], gie_r, tctrl_r[5:0]};
      // (RULE21) comparator state read-only
      `TIF_OFS_C1CTRL:  rdMux[7:0] = {2'b00, pinSync_r[13], c1ctrl_r[4:0]};
      `TIF_OFS_C23CTRL: rdMux[7:0] = c23ctrl_r;
      `TIF_OFS_WMASK:   rdMux[7:0] = wakeMask_r;
      `TIF_OFS_FMASK:   rdMux[7:0] = flagMask_r;
      `TIF_OFS_AUXCTRL: rdMux[7:0] = {6'h00, fourClk_r, convRun_r};
      `TIF_OFS_TMR:     rdMux[7:0] = tmr_r;
      `TIF_OFS_CNT1:    rdMux[15:0] = auxCnt_r[0];
      `TIF_OFS_CNT2:    rdMux[15:0] = auxCnt_r[1];
      `TIF_OFS_CNT3:    rdMux[15:0] = auxCnt_r[2];
      default:          mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setupPh;
      if (setupPh)
      begin
        prdata  <= rdMux;
        pslverr <= ~mapped;
      end
    end
  end

  // Plain read-write control registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tctrl_r    <= `TIF_RST_BYTE;
      c1ctrl_r   <= `TIF_RST_BYTE;
      c23ctrl_r  <= `TIF_RST_BYTE;
      wakeMask_r <= `TIF_RST_BYTE;
      flagMask_r <= `TIF_RST_BYTE;
    end
    else if (wrEn)
    begin
      case (apbReq.paddr)
        `TIF_OFS_TCTRL:   tctrl_r    <= wdByte;
        `TIF_OFS_C1CTRL:  c1ctrl_r   <= wdByte & `TIF_C1_WMASK;
        `TIF_OFS_C23CTRL: c23ctrl_r  <= wdByte & `TIF_C23_WMASK;
        `TIF_OFS_WMASK:   wakeMask_r <= wdByte;
        `TIF_OFS_FMASK:   flagMask_r <= wdByte;
        default:          tctrl_r    <= tctrl_r;
      endcase
    end
  end

  // (RULE16) global enable from instruction events
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      gie_r <= 1'b0;
    else if (hwEvt.irqDisable | hwEvt.irqTaken)
      gie_r <= 1'b0;
    else if (hwEvt.irqOn | hwEvt.irqReturn)
      gie_r <= 1'b1;
  end

  // (RULE20) four-clock mode halves the cycle rate
  assign cycleTick = ~fourClk_r | phase_r;

  // (RULE1) conversion start, result capture, running clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      convRun_r <= 1'b0;
      fourClk_r <= 1'b0;
      phase_r   <= 1'b0;
      resHi_r   <= `TIF_RST_BYTE;
      resLo_r   <= `TIF_RST_BYTE;
    end
    else
    begin
      phase_r <= ~phase_r;
      if (wrAux)
        fourClk_r <= wdByte[`TIF_BIT_FOURCLK];
      if (hwEvt.adcDone)
      begin
        resHi_r   <= {4'h0, hwEvt.adcResult[11:8]};
        resLo_r   <= hwEvt.adcResult[7:0];
        convRun_r <= 1'b0;
      end
      else if (wrAux & wdByte[`TIF_BIT_CONVRUN])
        convRun_r <= 1'b1;
    end
  end

  // Main timer source and prescaler
  // (RULE18) counted pin edge
  assign tccPinEvt = tctrl_r[`TIF_BIT_TEDGE] ? pinFall[0] : pinRise[0];
  // (RULE17) cycle clock or pin
  assign tmrSrcEvt = tctrl_r[`TIF_BIT_TSRC] ? tccPinEvt : cycleTick;
  // (RULE19) ratio two to the code plus one
  assign pMask  = `TIF_FULL_PMASK >> (3'd7 - tctrl_r[2:0]);
  assign tmrEvt = tctrl_r[`TIF_BIT_MAIN_PRESCALER_ENABLE]
                ? (tmrSrcEvt & ((presc_r & pMask) == pMask))
                : tmrSrcEvt;
  // (RULE25) wrap of the main timer
  assign tmrOvf = tmrEvt & (tmr_r == 8'hff);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      presc_r <= `TIF_RST_BYTE;
      tmr_r   <= `TIF_RST_BYTE;
    end
    else
    begin
      if (tmrSrcEvt)
        presc_r <= presc_r + 8'h01;
      if (tmrEvt)
        tmr_r <= tmr_r + 8'h01;
    end
  end

  // Auxiliary counter controls
  // (RULE21) counter one enable
  // (RULE22) counter one source and edge
  // (RULE24) counter two enable, source, edge
  assign auxEn   = {c23ctrl_r[2], c23ctrl_r[6], c1ctrl_r[2]};
  assign auxSrc  = {c23ctrl_r[1], c23ctrl_r[5], c1ctrl_r[1]};
  assign auxEdge = {c23ctrl_r[0], c23ctrl_r[4], c1ctrl_r[0]};

  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_aux
      logic        pinEvt;
      logic        evt;
      logic [15:0] top;
      assign pinEvt = auxEdge[k] ? pinFall[k+1] : pinRise[k+1];
      assign evt    = auxEn[k] & (auxSrc[k] ? pinEvt : cycleTick);
      // (RULE23) counter two width
      assign top = (k == 1 && c23ctrl_r[`TIF_BIT_WIDE]) ? `TIF_MAX16 : `TIF_MAX8;
      // (RULE25) increment, wrap, flag
      assign auxOvf[k] = evt & (auxCnt_r[k] == top);
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          auxCnt_r[k] <= `TIF_RST_WORD;
        else if (auxOvf[k])
          auxCnt_r[k] <= `TIF_RST_WORD;
        else if (evt)
          auxCnt_r[k] <= (auxCnt_r[k] + 16'h0001) & top;
      end
    end
  endgenerate

  // (RULE15) external pin edge choice
  assign extEdge = tctrl_r[`TIF_BIT_EXTEDGE] ? pinFall[4] : pinRise[4];
  assign portChg = |pinChg[12:5];
  // (RULE5) comparator output change
  assign cmpChg  = pinChg[13];

  // (RULE7) one bit per source, one means pending
  // (RULE10) pulse timer underflows
  // (RULE11) counter three overflow
  // (RULE12) counters two and one
  // (RULE13) external edge and port change
  // (RULE14) main timer overflow
  assign flagSet = {hwEvt.lowPulseUf, hwEvt.highPulseUf, auxOvf[2], auxOvf[1],
                    auxOvf[0], extEdge, portChg, tmrOvf};

  // (RULE9) write of zero clears, set wins
  assign flags_nxt = (flags_r & ~({8{wrFlags}} & ~wdByte)) | flagSet;

  // (RULE3) only clear bits five and four
  // (RULE4) conversion done sticky
  // (RULE6) wake enables are plain bits
  always_comb
  begin
    wake_nxt = wake_r;
    if (wrWake)
    begin
      wake_nxt[5:4] = wake_r[5:4] & wdByte[5:4];
      wake_nxt[3:1] = wdByte[3:1];
    end
    wake_nxt[`TIF_BIT_CONVERSION_DONE_FLAG]  = wake_nxt[`TIF_BIT_CONVERSION_DONE_FLAG] | hwEvt.adcDone;
    wake_nxt[`TIF_BIT_COMPARATOR_CHANGE_FLAG] = wake_nxt[`TIF_BIT_COMPARATOR_CHANGE_FLAG] | cmpChg;
    wake_nxt = wake_nxt & (`TIF_WAKE_WMASK | 8'h30);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      flags_r <= `TIF_RST_BYTE;
      wake_r  <= `TIF_RST_BYTE;
    end
    else
    begin
      flags_r <= flags_nxt;
      wake_r  <= wake_nxt;
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irqReq            <= 1'b0;
      wakeReq           <= 1'b0;
      globalIrqEnable   <= 1'b0;
      conversionRunning <= 1'b0;
    end
    else
    begin
      // (RULE26) mask bits gate the conversion and comparator requests
      irqReq <= |(flags_r & flagMask_r) | |(wake_r[5:4] & wakeMask_r[5:4]);
      // (RULE6) enabled sources wake the device
      wakeReq <= (wake_r[`TIF_BIT_CONVERSION_WAKE_ENABLE] & wake_r[`TIF_BIT_CONVERSION_DONE_FLAG])
               | (wake_r[`TIF_BIT_COMPARATOR_WAKE_ENABLE] & wake_r[`TIF_BIT_COMPARATOR_CHANGE_FLAG])
               | (wake_r[`TIF_BIT_PORT_CHANGE_WAKE_ENABLE] & flags_r[1]);
      globalIrqEnable   <= gie_r;
      conversionRunning <= convRun_r;
    end
  end

endmodule : tif_top

/* tb/tif_pin_model.sv */
// Model of the pins that surround the timer block.
// Assumes the bench requests each toggle for one clock.
`timescale 1ns/1ps
module tif_pin_model (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Toggle requests from the bench
  input  wire logic [13:0]  toggleReq,
  // Pins towards the block
  output tif_pkg::tif_pins_t pins
);
  import tif_pkg::*;
  // Pins change just after an edge
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      pins <= '0;
    else
      pins <= pins ^ toggleReq;
endmodule : tif_pin_model

/* tb/tif_top_props.sv */
// Assertions on the ports of the timer block.
// Assumes one clock domain and a wait-free APB slave.
`timescale 1ns/1ps
module tif_props (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // APB
  input wire tif_pkg::tif_apb_req_t apbReq,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Pins and events
  input wire tif_pkg::tif_pins_t    pins,
  input wire tif_pkg::tif_hw_t      hwEvt,
  // Status
  input wire logic                  irqReq,
  input wire logic                  wakeReq,
  input wire logic                  globalIrqEnable,
  input wire logic                  conversionRunning
);
  import tif_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire setup = apbReq.psel && !apbReq.penable;
  wire wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite && pready;
  wire unmapped = apbReq.paddr > 8'h34 || apbReq.paddr[1:0] != 2'h0;
  wire gieOn = (hwEvt.irqOn || hwEvt.irqReturn) && !hwEvt.irqDisable;
  wire gieOff = (hwEvt.irqDisable || hwEvt.irqTaken) && !hwEvt.irqOn;
  sequence s_rd(a);
    setup && !apbReq.pwrite && apbReq.paddr == a;
  endsequence
  a_ready_next: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_decode: assert property (setup |=> pslverr == $past(unmapped))
    else $error("pslverr wrong for address");
  a_hi_upper_zero: assert property (s_rd(8'h00) |=> prdata[31:4] == 28'h0)
    else $error("result high upper bits set");
  a_adc_stops_run: assert property (hwEvt.adcDone |-> ##2 !conversionRunning)
    else $error("running not cleared at conversion end");
  a_wake_reserved: assert property (s_rd(8'h08) |=> prdata[31:6] == 26'h0 && !prdata[0])
    else $error("wake status unused bits set");
  a_gie_set: assert property (gieOn && !hwEvt.irqTaken |-> ##2 globalIrqEnable)
    else $error("global enable not set");
  a_gie_clear: assert property (gieOff && !hwEvt.irqReturn |-> ##2 !globalIrqEnable)
    else $error("global enable not cleared");
  a_irq_sticky: assert property ($fell(irqReq) |-> $past(wrAcc) || $past(wrAcc, 2))
    else $error("interrupt request dropped without write");
  a_wake_sticky: assert property ($fell(wakeReq) |-> $past(wrAcc) || $past(wrAcc, 2))
    else $error("wake request dropped without write");
endmodule : tif_props
bind tif_top tif_props chk_u (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .hwEvt(hwEvt),
  .irqReq(irqReq), .wakeReq(wakeReq), .globalIrqEnable(globalIrqEnable),
  .conversionRunning(conversionRunning));

/* tb/tb_timer_and_interrupt_flags.sv */
// Self-checking bench for the timer and interrupt flag block.
// Assumes the pin model and the checker are compiled first.
`timescale 1ns/1ps
module tb_timer_and_interrupt_flags;
  import tif_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  tif_apb_req_t apbReq = '0;
  tif_hw_t      hwEvt = '0;
  tif_pins_t    pins;
  logic [13:0]  toggleReq = '0;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, er, irqReq, wakeReq, globalIrqEnable, conversionRunning;
  int           n_mismatch = 0;
  int           n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  tif_top dut_u (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .hwEvt(hwEvt), .irqReq(irqReq),
    .wakeReq(wakeReq), .globalIrqEnable(globalIrqEnable),
    .conversionRunning(conversionRunning));
  tif_pin_model pin_u (.clk_sys(clk_sys), .rst(rst), .toggleReq(toggleReq), .pins(pins));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk("pready wait", 32'h1, k);
    apbReq <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rdc
  task automatic hw(input tif_hw_t ev);
    @(posedge clk_sys);
    hwEvt <= ev;
    @(posedge clk_sys);
    hwEvt <= '0;
    repeat (3) @(posedge clk_sys);
  endtask : hw
  task automatic tog(input int b, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      toggleReq <= 14'h1 << b;
      @(posedge clk_sys);
      toggleReq <= '0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask : tog
  // Delta of a counter over a gap of cycles, or over three pin toggles
  task automatic cnt(input logic [7:0] a, input int gap, input int b, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] t;
    apb(1'b0, a, 32'h0);
    t = rd;
    if (b < 0)
      repeat (gap - 3) @(posedge clk_sys);
    else
      tog(b, 3);
    apb(1'b0, a, 32'h0);
    chk($sformatf("count %h", a), e, (rd - t) & m);
  endtask : cnt
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++)
      if (i != 10)
      begin
        rdc(8'(i * 4), 32'h0);
        chk("pslverr", 32'h0, {31'h0, er});
      end
    rdc(8'h38, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    $display("test reset done");
    wr(8'h24, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("running", 32'h1, {31'h0, conversionRunning});
    hw('{adcDone:1'b1, adcResult:12'habc, default:'0});
    chk("running", 32'h0, {31'h0, conversionRunning});
    rdc(8'h00, 32'h0a);
    wr(8'h04, 32'h55);
    rdc(8'h04, 32'hbc);
    rdc(8'h08, 32'h0);
    wr(8'h1c, 32'h20);
    rdc(8'h08, 32'h20);
    chk("irqReq", 32'h1, {31'h0, irqReq});
    wr(8'h1c, 32'hff);
    wr(8'h08, 32'hff);
    rdc(8'h08, 32'h2e);
    wr(8'h08, 32'h0e);
    rdc(8'h08, 32'h0e);
    tog(13, 1);
    rdc(8'h08, 32'h1e);
    chk("wakeReq", 32'h1, {31'h0, wakeReq});
    wr(8'h08, 32'h0e);
    rdc(8'h08, 32'h0e);
    $display("test conversion done");
    wr(8'h20, 32'hfe);
    hw('{lowPulseUf:1'b1, highPulseUf:1'b1, default:'0});
    tog(4, 1);
    tog(5, 1);
    rdc(8'h0c, 32'hc6);
    chk("wakeReq", 32'h1, {31'h0, wakeReq});
    chk("irqReq", 32'h1, {31'h0, irqReq});
    wr(8'h0c, 32'hff);
    rdc(8'h0c, 32'hc6);
    wr(8'h20, 32'h02);
    rdc(8'h0c, 32'h02);
    wr(8'h0c, 32'h0);
    wr(8'h20, 32'hfe);
    rdc(8'h0c, 32'h0);
    chk("wakeReq", 32'h0, {31'h0, wakeReq});
    wr(8'h10, 32'hc0);
    rdc(8'h10, 32'h80);
    tog(4, 1);
    rdc(8'h0c, 32'h04);
    wr(8'h0c, 32'h0);
    tog(4, 1);
    rdc(8'h0c, 32'h0);
    hw('{irqOn:1'b1, default:'0});
    rdc(8'h10, 32'hc0);
    hw('{irqTaken:1'b1, default:'0});
    chk("gie", 32'h0, {31'h0, globalIrqEnable});
    hw('{irqReturn:1'b1, default:'0});
    chk("gie", 32'h1, {31'h0, globalIrqEnable});
    hw('{irqDisable:1'b1, default:'0});
    chk("gie", 32'h0, {31'h0, globalIrqEnable});
    $display("test flags done");
    wr(8'h10, 32'h0);
    wr(8'h20, 32'h01);
    wr(8'h0c, 32'h0);
    repeat (260) @(posedge clk_sys);
    rdc(8'h0c, 32'h01);
    cnt(8'h28, 16, -1, 32'hff, 32'h10);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h10, 32'h8 | c);
      cnt(8'h28, 16 << (c + 1), -1, 32'hff, 32'h10);
    end
    wr(8'h10, 32'h0);
    wr(8'h24, 32'h2);
    cnt(8'h28, 16, -1, 32'hff, 32'h08);
    wr(8'h24, 32'h0);
    wr(8'h10, 32'h20);
    cnt(8'h28, 0, 0, 32'hff, 32'h02);
    wr(8'h10, 32'h30);
    cnt(8'h28, 0, 0, 32'hff, 32'h02);
    $display("test main timer done");
    wr(8'h14, 32'hff);
    rdc(8'h14, 32'h3f);
    wr(8'h18, 32'hff);
    rdc(8'h18, 32'hf7);
    wr(8'h18, 32'h0);
    cnt(8'h30, 20, -1, 32'hffff, 32'h0);
    wr(8'h14, 32'h04);
    wr(8'h18, 32'h44);
    cnt(8'h2c, 20, -1, 32'hff, 32'h14);
    cnt(8'h30, 300, -1, 32'hff, 32'h2c);
    chk("cnt2 upper", 32'h0, rd & 32'hff00);
    wr(8'h20, 32'h38);
    wr(8'h0c, 32'h0);
    repeat (260) @(posedge clk_sys);
    rdc(8'h0c, 32'h38);
    wr(8'h18, 32'hc4);
    cnt(8'h30, 300, -1, 32'hffff, 32'h12c);
    wr(8'h14, 32'h07);
    cnt(8'h2c, 0, 1, 32'hff, 32'h01);
    $display("test counters done");
    results();
  end
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    results();
  end
endmodule : tb_timer_and_interrupt_flags
